// File: shared/acg_pkg.sv
`default_nettype none
package acg_pkg;

  // ---------------------------------------------------------------
  // Area clock indices and masks
  // ---------------------------------------------------------------
  localparam int          N_AREA      = 10;
  localparam int          AREA_CIF    = 0;     // chan_iface_clk
  localparam int          AREA_CDX    = 1;     // chan_xfer_clk
  localparam int          AREA_ADT    = 2;     // auto_xfer_buffer_clk
  localparam int          AREA_DDC    = 3;     // device_ctl_clk
  localparam int          AREA_SDM    = 4;     // director_cpu_clk
  localparam int          AREA_REFRESH_CTL_CLK   = 5;     // refresh_ctl_clk
  localparam int          AREA_MNT    = 6;     // maint_logic clock
  localparam int          AREA_CSR    = 7;     // chan_reg_clk
  localparam int          AREA_CSC    = 8;     // chan_seq_clk
  localparam int          AREA_DCT    = 9;     // data_ctl_clk
  // Areas that restart by themselves after power-on reset
  localparam logic [9:0]  AUTO_MASK   = 10'h165;
  // Areas that a stop or a general start acts on
  localparam logic [9:0]  STOP_MASK   = ~AUTO_MASK;
  localparam logic [9:0]  START_MASK  = ~AUTO_MASK;
  // Areas stopped by a hardware check-1 error
  localparam logic [9:0]  CHK1_MASK   = 10'h29A;
  // Microprocessor area alone
  localparam logic [9:0]  CPU_MASK    = 10'h010;
  localparam logic [7:0]  PHASE_RST   = 8'h01;

  // ---------------------------------------------------------------
  // Register map and fields
  // ---------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL    = 8'h00; // maint_ctl_sense_reg
  localparam logic [7:0]  REG_IRQ     = 8'h04; // irq_level_reg
  localparam logic [7:0]  REG_STAT    = 8'h08; // clock status
  localparam int          CTRL_ARM_BIT  = 0;
  localparam int          IRQ_OVF_BIT   = 1;
  localparam int          IRQ_L1_BIT    = 6;
  localparam int          STAT_RING_BIT = 16;
  localparam int          STAT_HOLD_BIT = 17;
  localparam int          STAT_CHK1_BIT = 18;
  localparam int          STAT_CC1_BIT  = 19;
  localparam int          STAT_CC2_BIT  = 20;
  localparam logic        CTRL_RST      = 1'b0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          CLK_PERIOD_NS  = 40;
  localparam int          POR_DELAY_NS   = 250;
  localparam int          POR_DELAY_CYC  = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam real         REF_PERIOD_US  = 23.32;
  localparam int          REF_PERIOD_CYC = int'($floor(REF_PERIOD_US * 1000.0 / CLK_PERIOD_NS));
  localparam int          REF_BUSY_NS    = 440;
  localparam int          REF_BUSY_CYC   = REF_BUSY_NS / CLK_PERIOD_NS;
  localparam int          REARM_LOW_NS   = 220;
  localparam int          REARM_LOW_CYC  = (REARM_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TIMER_MS       = 650;
  localparam int          TIMER_CYC      = TIMER_MS * (1000000 / CLK_PERIOD_NS);

endpackage
`default_nettype wire

// File: core/acg_sync3.sv
`timescale 1ns/1ps
`default_nettype none
module acg_sync3 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ---------------------------------------------------------------
  // Three stages; output follows once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end
    else if (clk_en)
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q    <= (s2_q == s3_q) ? s3_q : q; // Filters a one-cycle glitch
    end
  end

endmodule // acg_sync3
`default_nettype wire

// File: core/acg_interval_timer.sv
`timescale 1ns/1ps
`default_nettype none
module acg_interval_timer #(
  parameter int unsigned TIMER_CYCLES = acg_pkg::TIMER_CYC,
  parameter int unsigned LOW_CYCLES   = acg_pkg::REARM_LOW_CYC
) (
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic arm,
  output var  logic overflow_q
);

  logic [23:0] cnt_q;
  logic [3:0]  low_q;
  wire         low_done = (low_q >= 4'(LOW_CYCLES - 1));
  wire         at_end   = (cnt_q == 24'(TIMER_CYCLES - 1));

  initial
  begin
    if (TIMER_CYCLES < 2 || TIMER_CYCLES > 24'hFFFFFF || LOW_CYCLES < 1 || LOW_CYCLES > 15)
      $error("acg_interval_timer: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // Count while armed; a short low glitch does not restart timing
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q      <= '0;
      low_q      <= '0;
      overflow_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!arm)
      begin
        overflow_q <= 1'b0;
        low_q      <= low_done ? low_q : low_q + 4'h1;
        cnt_q      <= low_done ? 24'h000000 : cnt_q;
      end
      else
      begin
        low_q      <= 4'h0;
        cnt_q      <= at_end ? cnt_q : cnt_q + 24'h000001;
        overflow_q <= overflow_q | at_end;
      end
    end
  end

endmodule // acg_interval_timer
`default_nettype wire

// File: core/acg_clock_gate_top.sv
//
// Contract
// - Ring makes eight phases, even and odd groups
// - Power-on reset holds the ring still
// - Ring starts about 250 ns after reset
// - Refresh and maintenance timing start with ring
// - Reset stops all; five areas restart alone
// - General start enables the remaining areas
// - Maintenance start enables only the processor
// - Stop halts all but five kept areas
// - Check 1 stops five processing area clocks
// - Channel checks never stop any clock
// - Refresh every 23.32 us lasting 440 ns
// - Hold only on dynamic storage access
// - Bit 0 arms timer, clear restarts it
// - Overflow flag after 650 ms armed
// - Overflow also raises level-1 interrupt bit
// - Clearing bit 0 clears overflow
// - Refresh wins over simultaneous processor request
`timescale 1ns/1ps
`default_nettype none
module acg_clock_gate_top #(
  parameter int unsigned TIMER_CYCLES = acg_pkg::TIMER_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // Pins from power and maintenance logic
  input  wire logic        por_in,
  input  wire logic        maint_start,
  input  wire logic        maint_cpu_start,
  input  wire logic        maint_stop,
  input  wire logic        check1_err,
  input  wire logic        chan_check1,
  input  wire logic        chan_check2,
  // Processor side, same clock
  input  wire logic        cpu_dyn_access,
  input  wire logic        cpu_stor_req,
  output logic             cpu_grant,
  output logic             refresh_grant,
  output logic             proc_hold,
  output logic             level1_irq,
  // Phases and gated area clocks
  output logic [3:0]       phase_even,
  output logic [3:0]       phase_odd,
  output logic [7:0]       chan_iface_clk,
  output logic [7:0]       chan_xfer_clk,
  output logic [7:0]       auto_xfer_buffer_clk,
  output logic [7:0]       device_ctl_clk,
  output logic [7:0]       director_cpu_clk,
  output logic [7:0]       refresh_ctl_clk,
  output logic [7:0]       maint_logic_clk,
  output logic [7:0]       chan_reg_clk,
  output logic [7:0]       chan_seq_clk,
  output logic [7:0]       data_ctl_clk,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [6:0] pins_s;
  wire        por_s    = pins_s[0];
  wire        start_s  = pins_s[1];
  wire        mstart_s = pins_s[2];
  wire        stop_s   = pins_s[3];
  wire        chk1_s   = pins_s[4];

  acg_sync3 #(.W(7)) u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .clk_en  (clk_en),
    .d       ({chan_check2, chan_check1, check1_err, maint_stop, maint_cpu_start, maint_start, por_in}),
    .q       (pins_s)
  );

  // ---------------------------------------------------------------
  // Clock ring and area enables
  // ---------------------------------------------------------------
  logic       ring_run_q, ring_run_d;
  logic [3:0] dly_q, dly_d;
  logic [7:0] phase_q, phase_d;
  logic [9:0] en_q, en_d;
  logic       hold_gate_q;
  logic       proc_hold_q;

  // Last phase ends a cycle; gating moves only here
  wire        boundary_w = clk_en & ring_run_q & phase_q[7];
  // Channel checks are absent from both masks on purpose
  wire [9:0]  set_w = (start_s ? acg_pkg::START_MASK : 10'h000)
                    | (mstart_s ? acg_pkg::CPU_MASK : 10'h000);
  wire [9:0]  clr_w = (stop_s ? acg_pkg::STOP_MASK : 10'h000)
                    | (chk1_s ? acg_pkg::CHK1_MASK : 10'h000);
  // Clear applied after set, so a stop beats a start
  wire [9:0]  en_next_w = ((en_q | set_w) & ~clr_w) | acg_pkg::AUTO_MASK;
  wire [9:0]  en_eff_w = en_q & ~(hold_gate_q ? acg_pkg::CPU_MASK : 10'h000) & {10{ring_run_q}};

  // Next state of ring, start-up delay and enables
  always_comb
  begin
    ring_run_d = ring_run_q;
    dly_d      = dly_q;
    phase_d    = phase_q;
    en_d       = en_q;
    if (por_s)
    begin
      ring_run_d = 1'b0;
      dly_d      = 4'h0;
      phase_d    = acg_pkg::PHASE_RST;
      en_d       = 10'h000;
    end
    else if (!ring_run_q)
    begin
      dly_d = dly_q + 4'h1;
      if (dly_q == 4'(acg_pkg::POR_DELAY_CYC - 1))
      begin
        ring_run_d = 1'b1;
        dly_d      = dly_q;
        en_d       = acg_pkg::AUTO_MASK;
      end
    end
    else
    begin
      phase_d = {phase_q[6:0], phase_q[7]};
      if (phase_q[7])
        en_d = en_next_w;
    end
  end

  // Ring and enable flops
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ring_run_q  <= 1'b0;
      dly_q       <= 4'h0;
      phase_q     <= acg_pkg::PHASE_RST;
      en_q        <= 10'h000;
      hold_gate_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ring_run_q  <= ring_run_d;
      dly_q       <= dly_d;
      phase_q     <= phase_d;
      en_q        <= en_d;
      hold_gate_q <= boundary_w ? proc_hold_q : hold_gate_q;
    end
  end

  // Phase groups and gated area buses
  assign phase_even           = {phase_q[6], phase_q[4], phase_q[2], phase_q[0]} & {4{ring_run_q}};
  assign phase_odd            = {phase_q[7], phase_q[5], phase_q[3], phase_q[1]} & {4{ring_run_q}};
  assign chan_iface_clk       = phase_q & {8{en_eff_w[acg_pkg::AREA_CIF]}};
  assign chan_xfer_clk        = phase_q & {8{en_eff_w[acg_pkg::AREA_CDX]}};
  assign auto_xfer_buffer_clk = phase_q & {8{en_eff_w[acg_pkg::AREA_ADT]}};
  assign device_ctl_clk       = phase_q & {8{en_eff_w[acg_pkg::AREA_DDC]}};
  assign director_cpu_clk     = phase_q & {8{en_eff_w[acg_pkg::AREA_SDM]}};
  assign refresh_ctl_clk      = phase_q & {8{en_eff_w[acg_pkg::AREA_REFRESH_CTL_CLK]}};
  assign maint_logic_clk      = phase_q & {8{en_eff_w[acg_pkg::AREA_MNT]}};
  assign chan_reg_clk         = phase_q & {8{en_eff_w[acg_pkg::AREA_CSR]}};
  assign chan_seq_clk         = phase_q & {8{en_eff_w[acg_pkg::AREA_CSC]}};
  assign data_ctl_clk         = phase_q & {8{en_eff_w[acg_pkg::AREA_DCT]}};

  // ---------------------------------------------------------------
  // Refresh timing and processor hold
  // ---------------------------------------------------------------
  logic [9:0] ref_cnt_q;
  logic [3:0] ref_busy_q;
  logic       ref_pend_q;
  wire        ref_run_w    = ring_run_q & en_q[acg_pkg::AREA_REFRESH_CTL_CLK];
  wire        ref_tick_w   = ref_run_w & (ref_cnt_q == 10'(acg_pkg::REF_PERIOD_CYC - 1));
  wire        ref_active_w = (ref_busy_q != 4'h0);
  wire        ref_start_w  = ref_pend_q & !ref_active_w;

  // Period counter, pending request, busy window
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_cnt_q   <= 10'h000;
      ref_pend_q  <= 1'b0;
      ref_busy_q  <= 4'h0;
      proc_hold_q <= 1'b0;
    end
    else if (clk_en)
    begin
      ref_cnt_q   <= (!ref_run_w || ref_tick_w) ? 10'h000 : ref_cnt_q + 10'h001;
      ref_pend_q  <= ref_tick_w | (ref_pend_q & !ref_start_w);
      ref_busy_q  <= ref_start_w ? 4'(acg_pkg::REF_BUSY_CYC) :
                     (ref_active_w ? ref_busy_q - 4'h1 : 4'h0);
      proc_hold_q <= ref_active_w & cpu_dyn_access;
    end
  end

  // Refresh owns storage while pending or busy
  assign refresh_grant = ref_active_w;
  assign cpu_grant     = cpu_stor_req & !ref_active_w & !ref_pend_q;
  assign proc_hold     = proc_hold_q;

  // ---------------------------------------------------------------
  // Interval timer and interrupt level bits
  // ---------------------------------------------------------------
  logic arm_q;
  logic ovf_w;

  acg_interval_timer #(
    .TIMER_CYCLES (TIMER_CYCLES),
    .LOW_CYCLES   (acg_pkg::REARM_LOW_CYC)
  ) u_timer (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .clk_en     (clk_en),
    .arm        (arm_q),
    .overflow_q (ovf_w)
  );

  assign level1_irq = ovf_w;

  // ---------------------------------------------------------------
  // AXI4-Lite register slave
  // ---------------------------------------------------------------
  logic        aw_hold_q, w_hold_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  wire         wr_fire_w  = aw_hold_q & w_hold_q & !s_axi_bvalid;
  wire         wr_ctrl_w  = (awaddr_q == acg_pkg::REG_CTRL);
  wire         wr_ok_w    = wr_ctrl_w || (awaddr_q == acg_pkg::REG_IRQ) || (awaddr_q == acg_pkg::REG_STAT);
  wire         rd_fire_w  = s_axi_arvalid & s_axi_arready;
  wire [31:0]  irq_word_w = (32'(ovf_w) << acg_pkg::IRQ_L1_BIT) | (32'(ovf_w) << acg_pkg::IRQ_OVF_BIT);
  wire [31:0]  stat_word_w = {11'h000, pins_s[6], pins_s[5], chk1_s, hold_gate_q, ring_run_q, 6'h00, en_eff_w};
  logic [31:0] rd_word_w;
  logic        rd_ok_w;

  assign s_axi_awready = !aw_hold_q & !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q & !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Read decode; unmapped reads return zero with an error
  always_comb
  begin
    rd_word_w = 32'h00000000;
    rd_ok_w   = 1'b1;
    if (s_axi_araddr == acg_pkg::REG_CTRL)
      rd_word_w = 32'(arm_q);
    else if (s_axi_araddr == acg_pkg::REG_IRQ)
      rd_word_w = irq_word_w;
    else if (s_axi_araddr == acg_pkg::REG_STAT)
      rd_word_w = stat_word_w;
    else
      rd_ok_w = 1'b0;
  end

  // Address and data may arrive in either order
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 8'h00;
      wdata_q      <= 32'h00000000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= acg_pkg::RESP_OKAY;
      arm_q        <= acg_pkg::CTRL_RST;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (wr_fire_w)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok_w ? acg_pkg::RESP_OKAY : acg_pkg::RESP_SLVERR;
        if (wr_ctrl_w && wstrb_q[0])
          arm_q <= wdata_q[acg_pkg::CTRL_ARM_BIT];
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= acg_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (rd_fire_w)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word_w;
        s_axi_rresp  <= rd_ok_w ? acg_pkg::RESP_OKAY : acg_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  ring_held_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (por_s && clk_en) |=> (!ring_run_q && phase_q == acg_pkg::PHASE_RST && en_q == 10'h000))
    else $error("ring not held during power-on reset");
  ring_delay_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(ring_run_q) |-> ($past(dly_q) == 4'(acg_pkg::POR_DELAY_CYC - 1)))
    else $error("ring started at wrong delay");
  auto_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(ring_run_q) |-> (en_q == acg_pkg::AUTO_MASK))
    else $error("wrong areas restarted after reset");
  ring_rotate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ring_run_q && !por_s && clk_en) |=>
      ($onehot(phase_q) && phase_q == {$past(phase_q[6:0]), $past(phase_q[7])}))
    else $error("phase ring did not rotate");
  gate_edge_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($changed(en_q) && !$past(por_s) && !$rose(ring_run_q)) |-> $past(boundary_w))
    else $error("enable changed off a phase boundary");
  stop_wins_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (boundary_w && stop_s && !por_s) |=>
      ((en_q & acg_pkg::STOP_MASK) == 10'h000 && (en_q & acg_pkg::AUTO_MASK) == acg_pkg::AUTO_MASK))
    else $error("stop left a gated area running");
  check1_stop_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (boundary_w && chk1_s && !por_s) |=> ((en_q & acg_pkg::CHK1_MASK) == 10'h000))
    else $error("check 1 did not stop areas");
  cpu_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (boundary_w && mstart_s && !start_s && !stop_s && !chk1_s && !por_s) |=>
      (en_q == ($past(en_q) | acg_pkg::CPU_MASK)))
    else $error("maintenance start touched other areas");
  gen_start_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (boundary_w && start_s && !stop_s && !chk1_s && !por_s) |=> (en_q == 10'h3FF))
    else $error("general start left an area stopped");
  hold_cause_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(proc_hold_q) |-> $past(ref_active_w && cpu_dyn_access))
    else $error("hold without dynamic access during refresh");
  refresh_prio_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ref_pend_q && cpu_stor_req) |-> !cpu_grant)
    else $error("processor granted over pending refresh");
  refresh_len_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(ref_active_w) |-> (ref_busy_q == 4'(acg_pkg::REF_BUSY_CYC)))
    else $error("refresh window has wrong length");
  ovf_clear_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!arm_q && clk_en) |=> !ovf_w && !irq_word_w[acg_pkg::IRQ_L1_BIT])
    else $error("overflow survived clearing bit 0");
  ovf_irq_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    irq_word_w[acg_pkg::IRQ_OVF_BIT] == irq_word_w[acg_pkg::IRQ_L1_BIT])
    else $error("level-1 bit disagrees with overflow");

endmodule // acg_clock_gate_top
`default_nettype wire

// File: verification/acg_cpu_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side processor: fetches from dynamic storage whenever it is allowed to run
module acg_cpu_partner (
  input  wire logic sys_clk,
  input  wire logic active,
  output var  logic cpu_dyn_access = 1'b0,
  output var  logic cpu_stor_req   = 1'b0
);
  // Requests are registered so they never move on the sampling edge
  always @(posedge sys_clk)
  begin
    cpu_stor_req   <= active;
    cpu_dyn_access <= active;
  end
endmodule // acg_cpu_partner
`default_nettype wire

// File: verification/acg_clock_gate_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module acg_clock_gate_top_tb_top;
  localparam int TCYC = 50;
  logic sys_clk, reset_n, por_in, maint_start, maint_cpu_start, maint_stop, check1_err, chan_check1, chan_check2;
  logic clk_en, cpu_dyn_access, cpu_stor_req, cpu_grant, refresh_grant, proc_hold, level1_irq;
  logic [3:0] phase_even, phase_odd, s_axi_wstrb;
  logic [7:0] chan_iface_clk, chan_xfer_clk, auto_xfer_buffer_clk, device_ctl_clk, director_cpu_clk;
  logic [7:0] refresh_ctl_clk, maint_logic_clk, chan_reg_clk, chan_seq_clk, data_ctl_clk;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int n_mismatch = 0;
  int num_checks = 0;
  int cycles = 0;
  acg_clock_gate_top #(.TIMER_CYCLES(TCYC)) acg_clock_gate_top_inst (.*);
  acg_cpu_partner acg_cpu_partner_inst (.sys_clk(sys_clk), .active(reset_n), .cpu_dyn_access(cpu_dyn_access),
    .cpu_stor_req(cpu_stor_req));
  // --------------------------------------------------------------
  // Clock, reset and hang guard
  // --------------------------------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Whole run needs about 1200 cycles; well past that is a hang
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Ready moves only on rising edges, so mid-cycle it equals what the next edge samples
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    @(negedge sys_clk);
    while (s_axi_awvalid || s_axi_wvalid)
    begin
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      @(posedge sys_clk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      @(negedge sys_clk);
    end
    while (!s_axi_bvalid) @(negedge sys_clk);
    @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge sys_clk); while (!s_axi_arready);
    @(posedge sys_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge sys_clk); while (!s_axi_rvalid);
    rd_q = s_axi_rdata;
    resp_q = s_axi_rresp;
    @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Sync plus wait for the next phase boundary takes at most about 13 cycles
  task automatic stat_is(input logic [9:0] exp);
    wt(16);
    rd(acg_pkg::REG_STAT);
    chk("area enables", {22'h0, exp}, {22'h0, rd_q[9:0]});
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_power_on;
    wt(16);
    chk("phases under por", 32'h0, {24'h0, phase_even, phase_odd});
    por_in <= 1'b0;
    stat_is(acg_pkg::AUTO_MASK);
    chk("ring running", 32'h1, {31'h0, rd_q[acg_pkg::STAT_RING_BIT]});
    @(negedge sys_clk);
    chk("cpu clock", 32'h0, {24'h0, director_cpu_clk});
    chk("one phase", 32'h1, $countones({phase_even, phase_odd}));
    chk("maint clock", {24'h0, phase_odd[3], phase_even[3], phase_odd[2], phase_even[2], phase_odd[1], phase_even[1],
      phase_odd[0], phase_even[0]}, {24'h0, maint_logic_clk});
    @(posedge sys_clk);
    $display("test power_on done");
  endtask
  task automatic t_maint;
    maint_cpu_start <= 1'b1;
    stat_is(acg_pkg::AUTO_MASK | acg_pkg::CPU_MASK);
    maint_cpu_start <= 1'b0;
    maint_start <= 1'b1;
    stat_is(10'h3FF);
    maint_start <= 1'b0;
    chan_check1 <= 1'b1;
    chan_check2 <= 1'b1;
    stat_is(10'h3FF);
    chk("chan checks", 32'h3, {30'h0, rd_q[acg_pkg::STAT_CC2_BIT], rd_q[acg_pkg::STAT_CC1_BIT]});
    maint_start <= 1'b1;
    check1_err <= 1'b1;
    stat_is(10'h3FF & ~acg_pkg::CHK1_MASK);
    check1_err <= 1'b0;
    stat_is(10'h3FF);
    maint_start <= 1'b0;
    maint_stop <= 1'b1;
    stat_is(acg_pkg::AUTO_MASK);
    maint_stop <= 1'b0;
    $display("test maint done");
  endtask
  // Clearing for 8 cycles keeps the 220 ns restart spacing
  task automatic t_timer;
    wr(acg_pkg::REG_CTRL, 32'h1);
    wt(30);
    wr(acg_pkg::REG_CTRL, 32'h0);
    wt(8);
    wr(acg_pkg::REG_CTRL, 32'h1);
    wt(30);
    rd(acg_pkg::REG_IRQ);
    chk("irq before expiry", 32'h0, rd_q);
    wt(30);
    chk("level1 line", 32'h1, {31'h0, level1_irq});
    rd(acg_pkg::REG_IRQ);
    chk("irq after expiry", 32'h42, rd_q);
    wr(acg_pkg::REG_CTRL, 32'h0);
    rd(acg_pkg::REG_IRQ);
    chk("irq cleared", 32'h0, rd_q);
    rd(8'hF0);
    chk("unmapped resp", {30'h0, acg_pkg::RESP_SLVERR}, {30'h0, resp_q});
    $display("test timer done");
  endtask
  // The partner always works from dynamic storage, so every refresh must hold it
  task automatic t_refresh;
    int n;
    n = 0;
    @(negedge sys_clk);
    while (!refresh_grant) @(negedge sys_clk);
    chk("cpu grant in refresh", 32'h0, {31'h0, cpu_grant});
    while (refresh_grant)
    begin
      @(negedge sys_clk);
      n++;
      if (n == 1) chk("processor hold", 32'h1, {31'h0, proc_hold});
    end
    chk("refresh length", acg_pkg::REF_BUSY_CYC, n);
    chk("cpu grant after", 32'h1, {31'h0, cpu_grant});
    while (!refresh_grant)
    begin
      @(negedge sys_clk);
      n++;
    end
    chk("refresh period", acg_pkg::REF_PERIOD_CYC, n);
    @(posedge sys_clk);
    $display("test refresh done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    {reset_n, maint_start, maint_cpu_start, maint_stop, check1_err, chan_check1, chan_check2} = 7'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    clk_en = 1'b1;
    por_in = 1'b1;
    wt(4);
    reset_n <= 1'b1;
    t_power_on();
    t_maint();
    t_timer();
    t_refresh();
    end_sim();
  end
endmodule // acg_clock_gate_top_tb_top
`default_nettype wire
